// [shared/mode_zero_pkg.sv]
/*
  Package for the mode register zero decoder: command and field layout,
  decode tables' sizes, reset values and the decoded-setting struct.
  Assumes a DDR4-style command bus sampled on a link clock that idles low between commands.
*/
package mode_zero_pkg;

  localparam int ADDR_W = 18;
  localparam int SEL_W = 3;
  localparam logic [2:0] SEL_MODE_ZERO = 3'h0;
  localparam logic [2:0] SEL_CONTROL_WORD = 3'h7;

  // field positions within the address bus
  localparam int WR_HI_BIT = 13;
  localparam int WR_LO_MSB = 11;
  localparam int WR_LO_LSB = 9;
  localparam int DLL_RESET_BIT = 8;
  localparam int TEST_MODE_BIT = 7;
  localparam int CL_HI_BIT = 12;
  localparam int CL_MID_MSB = 6;
  localparam int CL_MID_LSB = 4;
  localparam int BURST_TYPE_BIT = 3;
  localparam int CL_LO_BIT = 2;
  localparam int BL_MSB = 1;
  localparam int BL_LSB = 0;
  localparam int RESERVED_ADDR_BIT = 17;

  // write recovery / read-to-precharge table
  localparam logic [3:0] WR_LAST_CODE = 4'h8;
  localparam logic [5:0] WR_CODE6_CYCLES = 6'h18;
  localparam logic [5:0] WR_CODE7_CYCLES = 6'h16;
  localparam logic [5:0] WR_CODE8_CYCLES = 6'h1A;
  localparam logic [5:0] WR_BASE_CYCLES = 6'h0A;

  // burst length encodings
  localparam logic [1:0] BL_EIGHT = 2'h0;
  localparam logic [1:0] BL_PER_COMMAND = 2'h1;
  localparam logic [1:0] BL_CHOP = 2'h2;

  // precharge time in cycles, added to write recovery for the auto delay
  localparam logic [5:0] PRECHARGE_CYCLES = 6'h13;

  // reset values of the stored register
  localparam logic [17:0] MODE_ZERO_RESET = 18'h00000;

  // command encoding: act_n high, ras_n/cas_n/we_n all low is a set
  typedef struct packed {
    logic cs_n;
    logic act_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [17:0] addr;
  } cmd_bus_t;

  typedef struct packed {
    logic [5:0] write_recovery;
    logic [4:0] read_to_precharge_cycles;
    logic [6:0] autoprecharge_write_delay;
    logic [4:0] cas_latency_code;
    logic interleaved;
    logic dll_reset;
    logic test_mode_select;
    logic eight_beat_burst;
    logic per_command_burst_choice;
    logic four_beat_chop;
    logic reserved_code;
  } mode_zero_decoded_t;

endpackage

// [src/mode_zero_fields.sv]
/*
  Combinational decode of the stored 18-bit mode register zero image into
  the settings the rest of the device uses. Assumes a stable stored image.
*/
`timescale 1ns/1ns
module mode_zero_fields
  import mode_zero_pkg::*;
(
  // stored register image
  input wire logic [ADDR_W-1:0] image,
  // decoded settings
  output mode_zero_decoded_t settings
);

  logic [3:0] wr_code;
  logic [5:0] wr_cycles;
  logic wr_bad;

  always_comb begin
    wr_code = {image[WR_HI_BIT], image[WR_LO_MSB:WR_LO_LSB]};
    wr_bad = 1'b0;
    case (wr_code)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: begin
        wr_cycles = WR_BASE_CYCLES + {1'b0, wr_code[2:0], 1'b0, 1'b0} / 6'h2;
      end
      4'h6: wr_cycles = WR_CODE6_CYCLES;
      4'h7: wr_cycles = WR_CODE7_CYCLES;
      4'h8: wr_cycles = WR_CODE8_CYCLES;
      default: begin
        wr_cycles = 6'h00;
        wr_bad = 1'b1;
      end
    endcase
  end

  always_comb begin
    settings.write_recovery = wr_cycles;
    settings.read_to_precharge_cycles = wr_cycles[5:1];
    settings.autoprecharge_write_delay =
      {1'b0, wr_cycles} + {1'b0, PRECHARGE_CYCLES};
    settings.cas_latency_code = {image[CL_HI_BIT],
      image[CL_MID_MSB:CL_MID_LSB], image[CL_LO_BIT]};
    settings.interleaved = image[BURST_TYPE_BIT];
    settings.dll_reset = image[DLL_RESET_BIT];
    settings.test_mode_select = image[TEST_MODE_BIT];
    settings.eight_beat_burst =
      image[BL_MSB:BL_LSB] == BL_EIGHT;
    settings.per_command_burst_choice =
      image[BL_MSB:BL_LSB] == BL_PER_COMMAND;
    settings.four_beat_chop = image[BL_MSB:BL_LSB] == BL_CHOP;
    // 11 burst code and codes past 1000 are undefined settings
    settings.reserved_code = wr_bad | (&image[BL_MSB:BL_LSB]);
  end

endmodule // mode_zero_fields

// [src/sdram_mode_register_zero_decode.sv]
/*
  Mode register zero of the device: catches a mode register set command on
  the link clock, holds the 18-bit image and drives its decoded settings.
  Assumes the command pins and link clock arrive from outside the clk
  domain and stay stable for several clk periods around a link clock rise.
*/
// What this block does
// - select from BG0,BA1:0; selector 111 is ignored with no response
// - write recovery from A13,A11:A9: 10..20, 24, 22, 26; rest reserved
// - read-to-precharge delay is half the write recovery, 5 to 13
// - auto-precharge write delay is write recovery plus precharge time
// - burst length A1:A0: fixed eight, per command, fixed chop, reserved
// - latency code from A12,A6:A4,A2; controller uses supported values
`timescale 1ns/1ns
module sdram_mode_register_zero_decode
  import mode_zero_pkg::*;
#(
  // flops every pin passes before any logic reads it
  parameter int SYNC_DEPTH = 2
)
(
  // system
  input wire logic clk,
  input wire logic reset,
  // link pins
  input wire logic link_clk,
  input wire cmd_bus_t cmd_pins,
  // stored image and decoded settings
  output logic [ADDR_W-1:0] mode_register_zero,
  output mode_zero_decoded_t mode_settings,
  output logic loaded,
  output logic dll_reset_pulse
);

  localparam int CMD_W = $bits(cmd_bus_t);

  // fewer than two stages leaves metastability on the decode path;
  // more than four only adds latency the pin timing cannot spare
  if (SYNC_DEPTH < 2 || SYNC_DEPTH > 4) begin : g_bad_depth
    $error("SYNC_DEPTH must lie between 2 and 4");
  end

  // link clock: the sync stages plus one more for the edge compare
  logic [SYNC_DEPTH:0] lclk_sync_ff;
  logic [SYNC_DEPTH:0] nxt_lclk_sync;
  // command pins: one short shift chain per bit
  logic [SYNC_DEPTH-1:0] cmd_chain_ff [CMD_W];
  logic [SYNC_DEPTH-1:0] nxt_cmd_chain [CMD_W];
  logic [CMD_W-1:0] cmd_flat;
  cmd_bus_t cmd_seen;
  logic [ADDR_W-1:0] image_ff, nxt_image;
  mode_zero_decoded_t settings_ff;
  mode_zero_decoded_t dec_settings;
  logic loaded_ff, nxt_loaded;
  logic dll_pulse_ff, nxt_dll_pulse;
  logic link_rise;
  logic is_set_cmd;
  logic take_write;
  logic [SEL_W-1:0] sel;

  // link clock chain; idles low, so no false edge after reset
  always_comb begin
    nxt_lclk_sync = {lclk_sync_ff[SYNC_DEPTH-1:0], link_clk};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lclk_sync_ff <= '0;
    end else begin
      lclk_sync_ff <= nxt_lclk_sync;
    end
  end

  // every command bit passes the same number of stages as the link
  // clock, so the edge and the command it qualifies line up
  for (genvar b = 0; b < CMD_W; b++) begin : g_pin_sync
    always_comb begin
      nxt_cmd_chain[b] = {cmd_chain_ff[b][SYNC_DEPTH-2:0], cmd_pins[b]};
    end

    // reset to all ones: a deselected bus, never a set command
    always_ff @(posedge clk) begin
      if (reset) begin
        cmd_chain_ff[b] <= '1;
      end else begin
        cmd_chain_ff[b] <= nxt_cmd_chain[b];
      end
    end

    assign cmd_flat[b] = cmd_chain_ff[b][SYNC_DEPTH-1];
  end

  // edge found between the last sync stage and the extra one only
  always_comb begin
    cmd_seen = cmd_bus_t'(cmd_flat);
    link_rise = lclk_sync_ff[SYNC_DEPTH-1] & ~lclk_sync_ff[SYNC_DEPTH];
    sel = {cmd_seen.bg[0], cmd_seen.ba};
    is_set_cmd = ~cmd_seen.cs_n & cmd_seen.act_n &
      ~cmd_seen.ras_n & ~cmd_seen.cas_n & ~cmd_seen.we_n;
    // 111 belongs to the buffer control word: dropped with no sign
    take_write = link_rise & is_set_cmd & (sel != SEL_CONTROL_WORD) &
      (sel == SEL_MODE_ZERO);
  end

  // only selector 000 lands here; 111 is dropped silently, others
  // belong to other registers
  always_comb begin
    nxt_image = image_ff;
    nxt_loaded = loaded_ff;
    nxt_dll_pulse = 1'b0;
    if (take_write) begin
      // whole image replaced, no partial update
      nxt_image = cmd_seen.addr;
      nxt_loaded = 1'b1;
      nxt_dll_pulse = cmd_seen.addr[DLL_RESET_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      image_ff <= MODE_ZERO_RESET;
      loaded_ff <= 1'b0;
      dll_pulse_ff <= 1'b0;
      settings_ff <= '0;
    end else begin
      image_ff <= nxt_image;
      loaded_ff <= nxt_loaded;
      dll_pulse_ff <= nxt_dll_pulse;
      settings_ff <= dec_settings;
    end
  end

  mode_zero_fields u_fields (
    .image(image_ff),
    .settings(dec_settings)
  );

  always_comb begin
    mode_register_zero = image_ff;
    mode_settings = settings_ff;
    loaded = loaded_ff;
    dll_reset_pulse = dll_pulse_ff;
  end

endmodule // sdram_mode_register_zero_decode

// [bench/mode_zero_checker.sv]
/* Port checker for the mode register zero decoder.
   Assumes it is bound into the decoder top module. */
`timescale 1ns/1ns
module mode_zero_checker
  import mode_zero_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic reset,
  // link pins
  input wire logic link_clk,
  input wire cmd_bus_t cmd_pins,
  // watched outputs
  input wire logic [ADDR_W-1:0] mode_register_zero,
  input wire mode_zero_decoded_t mode_settings,
  input wire logic loaded,
  input wire logic dll_reset_pulse
);
  logic [17:0] m;
  mode_zero_decoded_t s;
  assign m = mode_register_zero;
  assign s = mode_settings;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_burst_eight: assert property (
    !$past(reset) && m[1:0] == 2'h0 |=> s.eight_beat_burst)
    else $error("eight beat burst not decoded");
  a_burst_chop: assert property (
    m[1:0] == 2'h2 |=> s.four_beat_chop && !s.eight_beat_burst)
    else $error("chop not decoded");
  a_burst_order: assert property (
    !$past(reset) |-> s.interleaved == $past(m[3]))
    else $error("burst ordering wrong");
  a_rtp_half: assert property (
    !s.reserved_code |-> {s.read_to_precharge_cycles, 1'h0} ==
      s.write_recovery)
    else $error("read to precharge not half");
  a_delay_sum: assert property (
    !$past(reset) && !s.reserved_code |-> s.autoprecharge_write_delay
      == 7'(s.write_recovery) + 7'(PRECHARGE_CYCLES))
    else $error("auto delay wrong");
  a_pulse_short: assert property (
    dll_reset_pulse |=> !dll_reset_pulse)
    else $error("dll pulse too long");
  a_pulse_cause: assert property (
    dll_reset_pulse |-> m[8] && loaded)
    else $error("dll pulse without cause");
  a_select_zero: assert property (
    !$past(reset) && $changed(m) |-> $past(cmd_pins.ba, 3) == 2'h0
      && !$past(cmd_pins.bg[0], 3))
    else $error("image changed for other selector");
  cover property (dll_reset_pulse);
  cover property ($rose(loaded));
  cover property (s.four_beat_chop);
endmodule // mode_zero_checker

// [bench/mode_zero_controller.sv]
/* Controller model: issues set commands on the link pins.
   Assumes the bench clock; link clock idles low between frames. */
`timescale 1ns/1ns
module mode_zero_controller
  import mode_zero_pkg::*;
(
  // system
  input wire logic clk,
  // link pins
  output logic link_clk,
  output cmd_bus_t cmd_pins
);
  initial begin
    link_clk = 1'h0;
    cmd_pins = '1;
  end
  task automatic send(input logic [2:0] sel, input logic [17:0] a);
    cmd_bus_t c;
    c = {5'h08, 1'h0, sel, a};
    c.addr[17] = 1'h0;
    cmd_pins <= c;
    repeat (8) @(posedge clk);
    link_clk <= 1'h1;
    repeat (8) @(posedge clk);
    link_clk <= 1'h0;
    repeat (8) @(posedge clk);
    // deselect; inverted lines so no stale value is seen
    cmd_pins <= ~c;
  endtask
endmodule // mode_zero_controller

// [bench/sdram_mode_register_zero_decode_test.sv]
/* Self-checking bench for the mode register zero decoder.
   Assumes the controller model drives the link pins. */
`timescale 1ns/1ns
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin \
  n_mismatch++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module sdram_mode_register_zero_decode_test
  import mode_zero_pkg::*;
;
  logic clk = 1'h0, reset = 1'h1, link_clk, loaded, pulse;
  cmd_bus_t cmd_pins;
  logic [17:0] img, ex;
  logic [5:0] w;
  mode_zero_decoded_t st;
  int checks = 0, n_mismatch = 0, n_pulse = 0, ex_pulse = 0;
  int seed = 32'h6A27;
  always #5 clk = ~clk;
  always @(posedge clk) if (pulse) n_pulse++;
  mode_zero_controller ctl_u (.clk(clk), .link_clk(link_clk),
    .cmd_pins(cmd_pins));
  sdram_mode_register_zero_decode dut_u (.clk(clk), .reset(reset),
    .link_clk(link_clk), .cmd_pins(cmd_pins), .mode_register_zero(img),
    .mode_settings(st), .loaded(loaded), .dll_reset_pulse(pulse));
  function automatic logic [5:0] wr_of(input logic [3:0] c);
    case (c)
      4'h6: return 6'h18;
      4'h7: return 6'h16;
      4'h8: return 6'h1A;
      default: return 6'h0A + {2'h0, c[2:0], 1'h0};
    endcase
  endfunction
  task automatic give_verdict;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    logic [17:0] a;
    logic [2:0] sel;
    ex = 18'h00000;
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 32; i++) begin
      a = 18'($random(seed));
      // only defined codes; test mode kept off
      {a[13], a[11:9]} = (i < 9) ? 4'(i) : 4'(i % 9);
      a[1:0] = 2'(i % 3);
      a[7] = 1'h0;
      a[17] = 1'h0;
      sel = (i % 4 == 3) ? 3'(i / 4) : 3'h0;
      if (sel == 3'h0) begin
        ex = a;
        ex_pulse += int'(a[8]);
      end
      @(posedge clk);
      ctl_u.send(sel, a);
      @(posedge clk);
      w = wr_of({ex[13], ex[11:9]});
      `CHK("image", ex, img)
      `CHK("wr", w, st.write_recovery)
      `CHK("rtp", 5'(w >> 1), st.read_to_precharge_cycles)
      `CHK("delay", 7'(w) + 7'h13, st.autoprecharge_write_delay)
      `CHK("cl", {ex[12], ex[6:4], ex[2]}, st.cas_latency_code)
      `CHK("bl", 3'h4 >> ex[1:0], {st.eight_beat_burst,
        st.per_command_burst_choice, st.four_beat_chop})
      `CHK("flags", {ex[3], ex[8], ex[7]}, {st.interleaved,
        st.dll_reset, st.test_mode_select})
      `CHK("rsv", 1'h0, st.reserved_code)
      `CHK("pulses", ex_pulse, n_pulse)
    end
    `CHK("loaded", 1'h1, loaded)
    give_verdict;
  end
endmodule // sdram_mode_register_zero_decode_test
bind sdram_mode_register_zero_decode mode_zero_checker chk_u (
  .clk(clk), .reset(reset), .link_clk(link_clk), .cmd_pins(cmd_pins),
  .mode_register_zero(mode_register_zero), .mode_settings(mode_settings),
  .loaded(loaded), .dll_reset_pulse(dll_reset_pulse));
